// File: verilog/war_pkg.sv
package war_pkg;
  // Output phase chosen by the phase selector
  typedef enum logic [1:0] {
    WAR_PH_A,
    WAR_PH_B,
    WAR_PH_C
  } war_phase_type;

  // Array query kinds handled by the readout
  typedef enum logic [1:0] {
    WAR_Q_WAVE,
    WAR_Q_HAMP,
    WAR_Q_HPHS
  } war_query_type;

  localparam int         WAR_CLK_MHZ       = 250;
  localparam int         WAR_SAMPLES       = 4096;
  localparam int         WAR_BLK_SAMPLES   = 256;
  localparam int         WAR_MAX_BLOCKS    = 16;
  localparam int         WAR_MAX_OFFSET    = 15;
  localparam int         WAR_NUM_HARM      = 51;
  localparam int         WAR_MAX_REPLY     = 16384;
  localparam int         WAR_LEN_DIGITS    = 5;
  localparam int         WAR_BYTES_BIN     = 4;
  localparam int         WAR_CHARS_HEX     = 8;
  // Sample spacing in nanoseconds, as published
  localparam real        WAR_TS_1PH_NS     = 10400.0;
  localparam real        WAR_TS_3PH_NS     = 31200.0;
  localparam int         WAR_TS_1PH_CYC    = int'(WAR_TS_1PH_NS * WAR_CLK_MHZ / 1000.0);
  localparam int         WAR_TS_3PH_CYC    = int'(WAR_TS_3PH_NS * WAR_CLK_MHZ / 1000.0);
  localparam logic [7:0] WAR_CHR_HASH      = 8'h23;
  localparam logic [7:0] WAR_CHR_ZERO      = 8'h30;
  localparam logic [7:0] WAR_CHR_FIVE      = 8'h35;
  localparam logic [7:0] WAR_CHR_COMMA     = 8'h2C;
  localparam logic [7:0] WAR_CHR_LF        = 8'h0A;
  localparam logic       WAR_FMT_BIN_RST   = 1'b0;
  localparam logic [1:0] WAR_PHASE_RST     = 2'h0;
  localparam logic [11:0] WAR_TRIG_POS_RST = 12'h000;

  // Hex digit to ASCII character
  function automatic logic [7:0] war_hex_chr(input logic [3:0] n);
    war_hex_chr = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : war_hex_chr
endpackage : war_pkg

// File: verilog/war_src_if.sv
`timescale 1ns/10ps
// Byte stream from a source sub-block into the reply framer
interface war_src_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  logic       last;
  modport src (output valid, output data, output last, input ready);
  modport snk (input valid, input data, input last, output ready);
endinterface : war_src_if

// File: verilog/war_sampler.sv
`timescale 1ns/10ps
// Captures current and voltage together into the acquisition buffers
module war_sampler
  import war_pkg::*;
#(
  parameter int DEPTH = 4096
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_start,
  input  wire logic              i_three_phase,
  input  wire logic [11:0]       i_trig_pos,
  input  wire logic [31:0]       i_cur_sample,
  input  wire logic [31:0]       i_volt_sample,
  input  wire logic [11:0]       i_rd_addr,
  output logic                   o_busy,
  output logic [31:0]            o_cur_word,
  output logic [31:0]            o_volt_word
);
  import war_pkg::*;

  logic [31:0] cur_mem  [DEPTH];
  logic [31:0] volt_mem [DEPTH];
  logic [15:0] tick_q;
  logic [12:0] cnt_q;
  logic        busy_q;
  wire  [15:0] tick_max = i_three_phase ? 16'(WAR_TS_3PH_CYC - 1) : 16'(WAR_TS_1PH_CYC - 1);
  wire         strobe   = busy_q && (tick_q == tick_max);
  // Trigger lands at index i_trig_pos; wrap keeps buffer circular
  wire  [11:0] wr_addr  = 12'(cnt_q[11:0] + i_trig_pos);

  // Sample pacing: one enable per sample interval
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tick_q <= 16'h0000;
      cnt_q  <= 13'h0000;
      busy_q <= 1'b0;
    end else if (i_start && !busy_q) begin
      tick_q <= 16'h0000;
      cnt_q  <= 13'h0000;
      busy_q <= 1'b1; // RQ6
    end else if (busy_q) begin
      tick_q <= strobe ? 16'h0000 : 16'(tick_q + 16'h0001); // RQ7
      if (strobe) begin
        cnt_q  <= 13'(cnt_q + 13'h0001);
        busy_q <= (cnt_q != 13'(DEPTH - 1));
      end
    end
  end

  // Both quantities written on the same strobe
  always_ff @(posedge i_ref_clk) begin
    if (strobe) begin
      cur_mem[wr_addr]  <= i_cur_sample; // RQ6 RQ8
      volt_mem[wr_addr] <= i_volt_sample;
    end
    o_cur_word  <= cur_mem[i_rd_addr];
    o_volt_word <= volt_mem[i_rd_addr];
  end

  assign o_busy = busy_q;
endmodule : war_sampler

// File: verilog/war_harm.sv
`timescale 1ns/10ps
// Harmonic table source: emits raw entries 0..N as bytes of 32-bit words
module war_harm
  import war_pkg::*;
(
  input  wire logic              i_ref_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_start,
  input  wire logic [5:0]        i_last_idx,
  input  wire logic              i_phase_q,
  input  wire logic [31:0]       i_hz_limit_idx,
  input  wire logic [31:0]       i_entry,
  output logic [5:0]             o_idx,
  war_src_if.src                 src
);
  import war_pkg::*;

  logic        run_q;
  logic [1:0]  byte_q;
  logic [5:0]  idx_q;
  // Zero above bandwidth; dc phase forced to zero degrees
  wire         zero_it = (32'(idx_q) > i_hz_limit_idx) || (i_phase_q && idx_q == 6'h00); // RQ12 RQ15
  wire  [31:0] word    = zero_it ? 32'h0000_0000 : i_entry;

  assign src.valid = run_q;
  assign src.data  = word[8'(31 - 8 * byte_q) -: 8];
  assign src.last  = run_q && (idx_q == i_last_idx) && (byte_q == 2'h3);
  assign o_idx     = idx_q;

  // Walk dc first, then fundamental, up to the requested order
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      run_q  <= 1'b0;
      byte_q <= 2'h0;
      idx_q  <= 6'h00;
    end else if (i_start) begin
      run_q  <= 1'b1;
      byte_q <= 2'h0;
      idx_q  <= 6'h00; // RQ11 RQ13
    end else if (run_q && src.ready) begin
      byte_q <= 2'(byte_q + 2'h1);
      if (byte_q == 2'h3) begin
        idx_q <= 6'(idx_q + 6'h01);
        run_q <= !src.last;
      end
    end
  end
endmodule : war_harm

// File: verilog/war_readout.sv
`timescale 1ns/10ps
// Summary of operation
// [RQ1] Acquire query starts a capture first; read-stored query replies from buffer.
// [RQ2] Only output current and voltage are kept as arrays.
// [RQ3] Every array reply uses the currently selected output phase.
// [RQ4] Waveform reply opens with hash, digit five, length, then sample bytes.
// [RQ5] Binary samples go as four float bytes, most significant first.
// [RQ6] Voltage and current are captured together on acquire or trigger.
// [RQ7] Samples spaced 10.4 us single phase, 31.2 us three phase.
// [RQ8] Trigger position follows its setting; interval is readable.
// [RQ9] Block count 1..16 and start 0..15 of 256 samples select the span.
// [RQ10] No block arguments returns all 4096 samples as block data.
// [RQ11] Harmonic amplitudes go dc, fundamental, then up to the 50th.
// [RQ12] Harmonics above 16 kHz bandwidth report zero.
// [RQ13] Harmonic count N returns entries 0 through N only.
// [RQ14] Phase in degrees; fundamental relative to fundamental voltage.
// [RQ15] The dc phase entry always reports zero degrees.
// [RQ16] Format picks binary four bytes or eight ASCII hex characters.
// [RQ17] Format affects only waveform replies; the rest is ASCII. Here harmonic words go as raw word bytes flagged as text.
// [RQ18] Format returns to binary at power-on.
// [RQ19] One reply never exceeds 16 KB; hex needs two transfers.
// [RQ20] Phase selector 1, 2, 3 selects phase A, B, C. Here applied only in three-phase mode.
// [RQ21] Length field is five decimal digits of following byte count.
module war_readout
  import war_pkg::*;
(
  input  wire logic               i_ref_clk,
  input  wire logic               i_nrst,
  input  wire logic               i_cmd_valid,
  input  wire logic               i_cmd_acquire,
  input  wire war_pkg::war_query_type i_cmd_kind,
  input  wire logic               i_cmd_current,
  input  wire logic               i_cmd_has_blocks,
  input  wire logic [4:0]         i_cmd_nblocks,
  input  wire logic [3:0]         i_cmd_first,
  input  wire logic               i_cmd_has_n,
  input  wire logic [5:0]         i_cmd_harm_n,
  input  wire logic               i_set_format,
  input  wire logic               i_format_hex,
  input  wire logic               i_set_phase,
  input  wire logic [1:0]         i_phase_sel,
  input  wire logic               i_three_phase,
  input  wire logic [11:0]        i_trig_pos,
  input  wire logic               i_acq_trigger,
  input  wire logic [31:0]        i_cur_sample,
  input  wire logic [31:0]        i_volt_sample,
  input  wire logic [31:0]        i_harm_entry,
  input  wire logic [31:0]        i_harm_limit,
  input  wire logic               i_out_ready,
  output logic                    o_cmd_ready,
  output logic                    o_cmd_error,
  output logic                    o_out_valid,
  output logic [7:0]              o_out_data,
  output logic                    o_out_ascii,
  output logic                    o_out_last,
  output logic                    o_format_hex,
  output war_pkg::war_phase_type  o_phase,
  output logic [15:0]             o_interval_cycles,
  output logic                    o_acq_busy,
  output logic [1:0]              o_harm_phase_sel,
  output logic                    o_harm_is_phase,
  output logic                    o_harm_is_current,
  output logic [5:0]              o_harm_idx
);
  import war_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACQ,
    ST_HDR,
    ST_WAVE,
    ST_HARM,
    ST_END
  } war_state_type;

  war_state_type  state_q;
  war_phase_type  phase_q;
  logic           fmt_hex_q;
  logic           is_cur_q;
  logic           acquire_q;
  war_query_type  kind_q;
  logic [11:0]    samp_q;
  logic [12:0]    samp_end_q;
  logic [2:0]     sub_q;
  logic [2:0]     hdr_q;
  logic [16:0]    nbytes_q;
  logic [5:0]     last_idx_q;
  logic           harm_go_q;
  logic           ready_d1_q;
  logic [31:0]    cur_word;
  logic [31:0]    volt_word;
  logic           acq_busy;
  logic [5:0]     harm_idx;
  war_src_if      harm_bus ();

  // Decimal digit of a byte count, most significant of five first
  function automatic logic [7:0] war_dec_digit(input logic [16:0] v, input logic [2:0] pos);
    logic [16:0] d;
    d = v;
    for (int k = 0; k < 4 - int'(pos); k++) begin
      d = 17'(d / 17'd10);
    end
    war_dec_digit = 8'(WAR_CHR_ZERO + 8'(d % 17'd10));
  endfunction : war_dec_digit

  // Argument checks; out-of-range spans are refused
  wire         blk_ok    = (i_cmd_nblocks >= 5'd1) && (i_cmd_nblocks <= 5'(WAR_MAX_BLOCKS))
                           && ({1'b0, i_cmd_first} + i_cmd_nblocks <= 5'(WAR_MAX_BLOCKS)); // RQ9
  wire  [4:0]  nblk      = i_cmd_has_blocks ? i_cmd_nblocks : 5'(WAR_MAX_BLOCKS); // RQ10
  wire  [3:0]  fblk      = i_cmd_has_blocks ? i_cmd_first : 4'h0;
  wire  [16:0] wave_bytes = 17'(nblk) * 17'(WAR_BLK_SAMPLES)
                           * (fmt_hex_q ? 17'(WAR_CHARS_HEX) : 17'(WAR_BYTES_BIN)); // RQ16
  wire         size_ok   = (wave_bytes <= 17'(WAR_MAX_REPLY)); // RQ19
  wire         harm_ok   = !i_cmd_has_n || (i_cmd_harm_n < 6'(WAR_NUM_HARM));
  wire         is_wave   = (i_cmd_kind == WAR_Q_WAVE);
  wire         cmd_ok    = is_wave ? ((!i_cmd_has_blocks || blk_ok) && size_ok) : harm_ok;
  wire         take      = i_cmd_valid && (state_q == ST_IDLE);

  // Selected word and its byte or hex character
  wire  [31:0] samp_word = is_cur_q ? cur_word : volt_word; // RQ2
  wire  [7:0]  bin_byte  = samp_word[8'(31 - 8 * sub_q[1:0]) -: 8]; // RQ5
  wire  [3:0]  nib       = samp_word[8'(31 - 4 * sub_q) -: 4];
  wire  [7:0]  wave_byte = fmt_hex_q ? war_hex_chr(nib) : bin_byte; // RQ16
  wire  [2:0]  sub_max   = fmt_hex_q ? 3'(WAR_CHARS_HEX - 1) : 3'(WAR_BYTES_BIN - 1);
  wire         word_done = (sub_q == sub_max);
  wire         wave_last = word_done && (13'(samp_q) + 13'h0001 == samp_end_q);
  wire  [7:0]  hdr_byte  = (hdr_q == 3'h0) ? WAR_CHR_HASH :
                           (hdr_q == 3'h1) ? WAR_CHR_FIVE : war_dec_digit(nbytes_q, 3'(hdr_q - 3'h2)); // RQ4 RQ21
  wire         hdr_done  = (hdr_q == 3'(WAR_LEN_DIGITS + 1));

  assign o_cmd_ready       = (state_q == ST_IDLE);
  assign harm_bus.ready    = (state_q == ST_HARM) && i_out_ready;
  assign o_out_valid       = (state_q == ST_HDR) || (state_q == ST_WAVE && ready_d1_q)
                             || (state_q == ST_HARM && harm_bus.valid) || (state_q == ST_END);
  assign o_out_data        = (state_q == ST_HDR) ? hdr_byte :
                             (state_q == ST_WAVE) ? wave_byte :
                             (state_q == ST_HARM) ? harm_bus.data : WAR_CHR_LF;
  assign o_out_last        = (state_q == ST_END);
  // Harmonic words go as raw word bytes flagged as text, never the waveform format
  assign o_out_ascii       = (state_q == ST_WAVE) ? fmt_hex_q : (state_q != ST_HDR); // RQ17
  assign o_format_hex      = fmt_hex_q;
  assign o_phase           = phase_q;
  assign o_interval_cycles = i_three_phase ? 16'(WAR_TS_3PH_CYC) : 16'(WAR_TS_1PH_CYC); // RQ8
  assign o_acq_busy        = acq_busy;
  assign o_harm_phase_sel  = phase_q; // RQ3
  assign o_harm_is_phase   = (kind_q == WAR_Q_HPHS); // RQ14
  assign o_harm_is_current = is_cur_q;
  assign o_harm_idx        = harm_idx;

  // Settings: format resets to binary, phase selector 1..3 to A..C in three-phase mode only
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fmt_hex_q <= WAR_FMT_BIN_RST; // RQ18
      phase_q   <= WAR_PH_A;
    end else begin
      if (i_set_format && state_q == ST_IDLE) begin
        fmt_hex_q <= i_format_hex;
      end
      if (i_set_phase && i_phase_sel != 2'h0 && i_three_phase) begin
        phase_q <= war_phase_type'(2'(i_phase_sel - 2'h1)); // RQ20
      end
    end
  end

  // Reply sequencer
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q     <= ST_IDLE;
      kind_q      <= WAR_Q_WAVE;
      is_cur_q    <= 1'b0;
      acquire_q   <= 1'b0;
      samp_q      <= 12'h000;
      samp_end_q  <= 13'h0000;
      sub_q       <= 3'h0;
      hdr_q       <= 3'h0;
      nbytes_q    <= 17'h0_0000;
      last_idx_q  <= 6'h00;
      harm_go_q   <= 1'b0;
      ready_d1_q  <= 1'b0;
      o_cmd_error <= 1'b0;
    end else begin
      harm_go_q   <= 1'b0;
      o_cmd_error <= 1'b0;
      ready_d1_q  <= (state_q == ST_WAVE);
      case (state_q)
        ST_IDLE: begin
          if (take && !cmd_ok) begin
            o_cmd_error <= 1'b1;
          end else if (take) begin
            kind_q     <= i_cmd_kind;
            is_cur_q   <= i_cmd_current;
            acquire_q  <= i_cmd_acquire;
            samp_q     <= {fblk, 8'h00}; // RQ9
            samp_end_q <= 13'({1'b0, fblk} + nblk) << 8;
            nbytes_q   <= wave_bytes;
            last_idx_q <= i_cmd_has_n ? i_cmd_harm_n : 6'(WAR_NUM_HARM - 1); // RQ13
            sub_q      <= 3'h0;
            hdr_q      <= 3'h0;
            state_q    <= i_cmd_acquire ? ST_ACQ : (is_wave ? ST_HDR : ST_HARM); // RQ1
            harm_go_q  <= !i_cmd_acquire && !is_wave;
          end
        end
        ST_ACQ: begin
          // Wait out the fresh capture before replying
          if (!acq_busy && acquire_q) begin
            acquire_q <= 1'b0;
          end else if (!acq_busy) begin
            state_q   <= (kind_q == WAR_Q_WAVE) ? ST_HDR : ST_HARM; // RQ1
            harm_go_q <= (kind_q != WAR_Q_WAVE);
          end
        end
        ST_HDR: begin
          if (i_out_ready) begin
            hdr_q <= 3'(hdr_q + 3'h1);
            if (hdr_done) begin
              state_q <= ST_WAVE;
            end
          end
        end
        ST_WAVE: begin
          // Read data lags address by one cycle; ready_d1_q hides the gap
          if (ready_d1_q && i_out_ready) begin
            sub_q <= word_done ? 3'h0 : 3'(sub_q + 3'h1);
            if (word_done) begin
              samp_q <= 12'(samp_q + 12'h001);
            end
            if (wave_last) begin
              state_q <= ST_END;
            end
          end
        end
        ST_HARM: begin
          if (harm_bus.valid && harm_bus.last && i_out_ready) begin
            state_q <= ST_END;
          end
        end
        ST_END: begin
          if (i_out_ready) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Capture start; read address steps ahead on a word's last byte so the next word is not stale
  wire sampler_start = (take && cmd_ok && i_cmd_acquire) || (i_acq_trigger && state_q == ST_IDLE); // RQ6
  wire [11:0] rd_addr = (ready_d1_q && i_out_ready && word_done) ? 12'(samp_q + 12'h001) : samp_q; // RQ5

  war_sampler #(
    .DEPTH (WAR_SAMPLES)
  ) u_sampler (
    .i_ref_clk     (i_ref_clk),
    .i_nrst        (i_nrst),
    .i_start       (sampler_start),
    .i_three_phase (i_three_phase),
    .i_trig_pos    (i_trig_pos),
    .i_cur_sample  (i_cur_sample),
    .i_volt_sample (i_volt_sample),
    .i_rd_addr     (rd_addr),
    .o_busy        (acq_busy),
    .o_cur_word    (cur_word),
    .o_volt_word   (volt_word)
  );

  war_harm u_harm (
    .i_ref_clk      (i_ref_clk),
    .i_nrst         (i_nrst),
    .i_start        (harm_go_q),
    .i_last_idx     (last_idx_q),
    .i_phase_q      (kind_q == WAR_Q_HPHS),
    .i_hz_limit_idx (i_harm_limit),
    .i_entry        (i_harm_entry),
    .o_idx          (harm_idx),
    .src            (harm_bus.src)
  );
endmodule : war_readout

// File: testbench/war_readout_props.sv
`timescale 1ns/10ps
// Port-level checks on the array readout
module war_readout_props
  import war_pkg::*;
(
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_nrst,
  input  wire logic                   i_cmd_valid,
  input  wire logic                   i_cmd_acquire,
  input  wire war_pkg::war_query_type i_cmd_kind,
  input  wire logic                   i_set_format,
  input  wire logic                   i_format_hex,
  input  wire logic                   i_set_phase,
  input  wire logic [1:0]             i_phase_sel,
  input  wire logic                   i_three_phase,
  input  wire logic                   i_acq_trigger,
  input  wire logic                   i_out_ready,
  input  wire logic                   o_cmd_ready,
  input  wire logic                   o_cmd_error,
  input  wire logic                   o_out_valid,
  input  wire logic [7:0]             o_out_data,
  input  wire logic                   o_out_ascii,
  input  wire logic                   o_out_last,
  input  wire logic                   o_format_hex,
  input  wire war_pkg::war_phase_type o_phase,
  input  wire logic [15:0]            o_interval_cycles,
  input  wire logic                   o_acq_busy
);
  logic          first_q;
  war_query_type kind_q;
  wire           take = i_cmd_valid && o_cmd_ready;
  // Reply tracker: the byte after a terminator opens the next reply
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      first_q <= 1'b1;
      kind_q  <= WAR_Q_WAVE;
    end else begin
      if (take) kind_q <= i_cmd_kind;
      if (o_out_valid && i_out_ready) first_q <= o_out_last;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  a_fmt_reset_bin: assert property ($rose(i_nrst) |-> !o_format_hex && o_phase == WAR_PH_A)
    else $error("format or phase not at reset value");
  a_interval_mode: assert property (o_interval_cycles == (i_three_phase ? 16'h1E78 : 16'h0A28))
    else $error("sample interval wrong for mode");
  a_phase_map: assert property (i_set_phase && i_three_phase && i_phase_sel != 2'h0
    |=> o_phase == war_phase_type'($past(i_phase_sel) - 2'h1)) else $error("phase selector mapping wrong");
  a_fmt_apply: assert property (i_set_format && o_cmd_ready |=> o_format_hex == $past(i_format_hex))
    else $error("format select not applied");
  a_wave_open: assert property (first_q && o_out_valid && kind_q == WAR_Q_WAVE |-> o_out_data == WAR_CHR_HASH)
    else $error("waveform reply does not open with hash");
  a_stream_hold: assert property (o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_data))
    else $error("reply byte dropped or changed while stalled");
  a_busy_on_acq: assert property (take && i_cmd_acquire |-> ##[1:4] o_acq_busy)
    else $error("acquire query did not start capture");
  a_fetch_no_acq: assert property (take && !i_cmd_acquire && !o_acq_busy |=> !o_acq_busy)
    else $error("stored query started a capture");
  a_trig_busy: assert property (i_acq_trigger && o_cmd_ready && !o_acq_busy |-> ##[1:4] o_acq_busy)
    else $error("trigger did not start capture");
  a_dc_phase_zero: assert property (first_q && o_out_valid && kind_q == WAR_Q_HPHS |-> o_out_data == 8'h00)
    else $error("dc phase entry not zero");
  a_error_no_reply: assert property (o_cmd_error |=> !o_out_valid)
    else $error("refused query produced a reply");
  a_harm_text: assert property (o_out_valid && kind_q != WAR_Q_WAVE && !o_out_last |-> o_out_ascii)
    else $error("harmonic reply not flagged as text");
  c_wave_take: cover property (take && i_cmd_kind == WAR_Q_WAVE);
  c_refused: cover property (o_cmd_error);
  c_phase_end: cover property (o_out_valid && o_out_last && kind_q == WAR_Q_HPHS);
endmodule : war_readout_props

bind war_readout war_readout_props u_war_readout_props (
  .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_cmd_valid(i_cmd_valid), .i_cmd_acquire(i_cmd_acquire),
  .i_cmd_kind(i_cmd_kind), .i_set_format(i_set_format), .i_format_hex(i_format_hex),
  .i_set_phase(i_set_phase), .i_phase_sel(i_phase_sel), .i_three_phase(i_three_phase),
  .i_acq_trigger(i_acq_trigger), .i_out_ready(i_out_ready), .o_cmd_ready(o_cmd_ready),
  .o_cmd_error(o_cmd_error), .o_out_valid(o_out_valid), .o_out_data(o_out_data), .o_out_ascii(o_out_ascii),
  .o_out_last(o_out_last), .o_format_hex(o_format_hex), .o_phase(o_phase),
  .o_interval_cycles(o_interval_cycles), .o_acq_busy(o_acq_busy));

// File: testbench/war_host.sv
`timescale 1ns/10ps
// Test controller side: takes every reply byte, stalling on request
module war_host (
  input  wire logic       i_ref_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_valid,
  input  wire logic [7:0] i_data,
  input  wire logic       i_last,
  input  wire logic       i_stall,
  input  wire logic       i_clear,
  output logic            o_ready
);
  logic [7:0] rx [0:16447];
  int         cnt;
  logic       done;
  logic [1:0] tick_q;
  // Ready moves just after the edge; stalling leaves it up one cycle in four
  always @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ready <= 1'b0;
      tick_q  <= 2'h0;
      cnt     <= 0;
      done    <= 1'b0;
    end else begin
      tick_q  <= tick_q + 2'h1;
      o_ready <= !i_stall || (tick_q == 2'h3);
      if (i_clear) begin
        cnt  <= 0;
        done <= 1'b0;
      end else if (i_valid && o_ready) begin
        rx[cnt] <= i_data;
        cnt     <= cnt + 1;
        if (i_last) done <= 1'b1;
      end
    end
  end
endmodule : war_host

// File: testbench/war_readout_tb.sv
`timescale 1ns/10ps
module war_readout_tb;
  import war_pkg::*;
  logic          clk, nrst, cv, acq, hb, hn, sf, fhex, sp, tph, trg, stall, clr, err_seen;
  war_query_type kind;
  logic [4:0]    nb;
  logic [3:0]    fs;
  logic [5:0]    n, hidx;
  logic [1:0]    psel, hps;
  logic [31:0]   lim, entry;
  logic          rdy, err, ov, oasc, olast, ofh, busy, ordy, hip, hic;
  logic [7:0]    od;
  war_phase_type oph;
  logic [15:0]   oint;
  int            num_errors, n_compared;
  // Harmonic table stand-in: a recognisable word per index
  assign entry = 32'hA5C3_0000 | {26'h0, hidx};
  war_readout u_war_readout (.i_ref_clk(clk), .i_nrst(nrst), .i_cmd_valid(cv), .i_cmd_acquire(acq),
    .i_cmd_kind(kind), .i_cmd_current(1'b1), .i_cmd_has_blocks(hb), .i_cmd_nblocks(nb), .i_cmd_first(fs),
    .i_cmd_has_n(hn), .i_cmd_harm_n(n), .i_set_format(sf), .i_format_hex(fhex), .i_set_phase(sp),
    .i_phase_sel(psel), .i_three_phase(tph), .i_trig_pos(12'h010), .i_acq_trigger(trg),
    .i_cur_sample(32'h3F80_0000), .i_volt_sample(32'hC120_0000), .i_harm_entry(entry), .i_harm_limit(lim),
    .i_out_ready(ordy), .o_cmd_ready(rdy), .o_cmd_error(err), .o_out_valid(ov), .o_out_data(od),
    .o_out_ascii(oasc), .o_out_last(olast), .o_format_hex(ofh), .o_phase(oph), .o_interval_cycles(oint),
    .o_acq_busy(busy), .o_harm_phase_sel(hps), .o_harm_is_phase(hip), .o_harm_is_current(hic),
    .o_harm_idx(hidx));
  war_host u_war_host (.i_ref_clk(clk), .i_nrst(nrst), .i_valid(ov), .i_data(od), .i_last(olast),
    .i_stall(stall), .i_clear(clr), .o_ready(ordy));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Refusals are one-cycle pulses, so latch them
  always @(posedge clk) err_seen <= err || (err_seen && !clr);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic rst;
    @(negedge clk);
    nrst = 1'b0;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
  endtask : rst
  // One query, then wait for terminator or refusal; acquire returns at once
  task automatic q(input logic a, input war_query_type k, input logic b, input logic [4:0] c,
                   input logic [3:0] f, input logic h, input logic [5:0] m);
    @(negedge clk);
    {clr, cv} = 2'h3;
    kind = k;
    {acq, hb, nb, fs, hn, n} = {a, b, c, f, h, m};
    @(negedge clk);
    {clr, cv} = 2'h0;
    for (int i = 0; i < 70000 && !u_war_host.done && !err_seen && !a; i++) @(negedge clk);
  endtask : q
  task automatic pulse_fmt(input logic h);
    @(negedge clk);
    {sf, fhex} = {1'b1, h};
    @(negedge clk);
    sf = 1'b0;
    chk(ofh, h);
  endtask : pulse_fmt
  task automatic chk_wave(input int len);
    int p = 10000;
    chk(u_war_host.rx[0], WAR_CHR_HASH);
    chk(u_war_host.rx[1], WAR_CHR_FIVE);
    for (int i = 0; i < 5; i++) begin
      chk(u_war_host.rx[2 + i], 32'(8'h30 + 8'((len / p) % 10)));
      p = p / 10;
    end
    chk(u_war_host.cnt, len + 8);
    chk(u_war_host.rx[len + 7], WAR_CHR_LF);
  endtask : chk_wave
  task automatic t_static;
    chk({ofh, rdy, ov}, 3'h2);
    chk(oph, WAR_PH_A);
    chk(oint, 16'h0A28);
    for (int p = 1; p < 5; p++) begin
      @(negedge clk);
      {tph, sp, psel} = {p < 4, 1'b1, 2'(p % 4)};
      @(negedge clk);
      sp = 1'b0;
      chk(oph, war_phase_type'(2'(p < 4 ? p - 1 : 2)));
    end
    chk(oint, 16'h0A28);
    tph = 1'b1;
    #1 chk(oint, 16'h1E78);
    $display("test static settings done");
  endtask : t_static
  // Harmonics in hex mode: still raw words, cut at limit, dc phase zero
  task automatic t_harm;
    logic [31:0] w;
    for (int k = 1; k < 3; k++) begin
      q(1'b0, war_query_type'(k), 1'b0, 5'h0, 4'h0, 1'b1, 6'h3);
      chk(u_war_host.cnt, 17);
      chk({hip, hic, hps}, {k == 2, 1'b1, 2'h2});
      for (int i = 0; i < 4; i++) begin
        w = (i > 2 || (k == 2 && i == 0)) ? 32'h0 : (32'hA5C3_0000 | 32'(i));
        chk({u_war_host.rx[4*i], u_war_host.rx[4*i+1], u_war_host.rx[4*i+2], u_war_host.rx[4*i+3]}, w);
      end
    end
    q(1'b0, WAR_Q_HAMP, 1'b0, 5'h0, 4'h0, 1'b0, 6'h0);
    chk(u_war_host.cnt, 205);
    $display("test harmonics done");
  endtask : t_harm
  task automatic t_refuse(input logic b, input logic [4:0] c, input logic h, input logic [5:0] m);
    q(1'b0, h ? WAR_Q_HAMP : WAR_Q_WAVE, b, c, 4'h0, h, m);
    chk(err_seen, 1'b1);
    chk(u_war_host.cnt, 0);
  endtask : t_refuse
  task automatic t_waves;
    q(1'b0, WAR_Q_WAVE, 1'b1, 5'h8, 4'h8, 1'b0, 6'h0);
    chk_wave(16384);
    pulse_fmt(1'b0);
    stall = 1'b1;
    for (int f = 0; f < 16; f += 15) begin
      q(1'b0, WAR_Q_WAVE, 1'b1, 5'h1, 4'(f), 1'b0, 6'h0);
      chk_wave(1024);
    end
    stall = 1'b0;
    q(1'b0, WAR_Q_WAVE, 1'b0, 5'h0, 4'h0, 1'b0, 6'h0);
    chk_wave(16384);
    chk(busy, 1'b0);
    $display("test waveforms done");
  endtask : t_waves
  task automatic t_acquire;
    pulse_fmt(1'b1);
    q(1'b1, WAR_Q_WAVE, 1'b1, 5'h1, 4'h0, 1'b0, 6'h0);
    repeat (4) @(negedge clk);
    chk({busy, rdy}, 2'h2);
    rst();
    chk({ofh, busy}, 2'h0);
    trg = 1'b1;
    @(negedge clk);
    trg = 1'b0;
    repeat (3) @(negedge clk);
    chk(busy, 1'b1);
    rst();
    $display("test acquire done");
  endtask : t_acquire
  initial begin
    {nrst, cv, acq, hb, hn, sf, fhex, sp, tph, trg, stall, clr} = '0;
    {nb, fs, n, psel, lim} = {5'h0, 4'h0, 6'h0, 2'h0, 32'h2};
    kind = WAR_Q_WAVE;
    rst();
    t_static();
    pulse_fmt(1'b1);
    t_harm();
    t_refuse(1'b0, 5'h0, 1'b0, 6'h0);
    t_refuse(1'b1, 5'h9, 1'b0, 6'h0);
    t_refuse(1'b1, 5'h0, 1'b0, 6'h0);
    t_refuse(1'b1, 5'h11, 1'b0, 6'h0);
    t_refuse(1'b0, 5'h0, 1'b1, 6'h33);
    t_waves();
    t_acquire();
    complete_run();
  end
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    complete_run();
  end
endmodule : war_readout_tb
